// ---- design/pos_drive_consts.vh ----
// Purpose : Shared constants for the positioner clutch magnet drive control
// Assumes : 100 MHz system clock, pickup pulses arrive as logic-level pins
// Notes   : Timing counts are derived from times in ns and the clock period
`ifndef POS_DRIVE_CONSTS_VH
`define POS_DRIVE_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS   10
`define PULSE_MIN_NS    1000
`define PULSE_MIN_CYC   ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CNT_W      8

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define CHAN_COUNT      3
`define PICK_PHASE_POS  0
`define PICK_PHASE_NEG  1
`define PICK_CODE_NEG   2
`define PICK_COUNT      3
`define PHASE_ZERO      1'b0
`define PHASE_ONE       1'b1
`define RST_PHASE       1'b0
`define RST_POS         3'h0

`endif

// ---- design/magnet_channel.v ----
// Purpose : One eccentric's clutch magnet pair selection
// Assumes : load_i is a one-cycle pulse at the negative code timing pulse
// Notes   : Magnets hold their state between loads; both off while disabled
`include "pos_drive_consts.vh"

module magnet_channel (
   input  wire sys_clk_i,   // System clock
   input  wire rst_i,       // Synchronous reset, active high
   input  wire load_i,      // Start of excitation interval
   input  wire enable_i,    // Drive permitted
   input  wire phase_i,     // Phase that applies to the coming interval
   input  wire code_i,      // Code bit for this eccentric
   input  wire single_i,    // Spring replaces the left magnet
   output reg  left_o,      // Left-pull magnet drive
   output reg  right_o      // Right-pull magnet drive
);

   // ****************************************************************
   // Selection
   // ****************************************************************
   reg right_sel;
   reg left_sel;

   // Exclusive-OR chooses the direction; the spring variant uses plain OR
   always @* begin
      if (single_i) begin
         right_sel = phase_i | code_i;
         left_sel  = 1'b0;
      end else begin
         right_sel = phase_i ^ code_i;
         left_sel  = ~(phase_i ^ code_i);
      end
   end

   // Drive only changes on the load pulse, so it stands for the whole
   // interval and stays on through the coupled rotation
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         left_o  <= 1'b0;
         right_o <= 1'b0;
      end else if (!enable_i) begin
         left_o  <= 1'b0;
         right_o <= 1'b0;
      end else if (load_i) begin
         left_o  <= left_sel;
         right_o <= right_sel;
      end
   end

endmodule // magnet_channel

// ---- design/positioner_magnet_drive.v ----
// Purpose : Clutch magnet drive control for a three-bit digital positioner
// Assumes : Pickup and code inputs are asynchronous pins; code source holds
//           its bits stable across the negative code timing pulse
// Notes   : The positive code timing pulse belongs to companion equipment
//           and has no port here
`include "pos_drive_consts.vh"

module positioner_magnet_drive #(
   parameter integer CHANNELS = `CHAN_COUNT,    // Positioner bits
   parameter integer FILT_W   = `FILT_CNT_W     // Pulse filter counter width
) (
   input  wire                sys_clk_i,        // System clock, 100 MHz
   input  wire                rst_i,            // Synchronous reset, active high
   input  wire                phase_pos_i,      // Phase pickup positive pulse
   input  wire                phase_neg_i,      // Phase pickup negative pulse
   input  wire                code_neg_i,       // Code timing negative pulse
   input  wire [CHANNELS-1:0] code_bit_i,       // Code bits from the source
   input  wire                single_mag_i,     // Spring-return variant fitted
   output wire [CHANNELS-1:0] mag_left_o,       // Left-pull magnet drives
   output wire [CHANNELS-1:0] mag_right_o,      // Right-pull magnet drives
   output reg                 phase_o,          // Phase of current interval
   output reg  [CHANNELS-1:0] pos_sel_o,        // Selected output position
   output reg                 running_o         // Magnet drive active
);

   // ****************************************************************
   // Input synchronisers and pulse filters
   // ****************************************************************
   // Filter limit cut to the counter width on purpose
   localparam [31:0]       PULSE_LAST_W = `PULSE_MIN_CYC - 1;
   localparam [FILT_W-1:0] PULSE_LAST   = PULSE_LAST_W[FILT_W-1:0];

   wire [`PICK_COUNT-1:0] pick_raw;
   wire [`PICK_COUNT-1:0] pick_pulse;

   assign pick_raw[`PICK_PHASE_POS] = phase_pos_i;
   assign pick_raw[`PICK_PHASE_NEG] = phase_neg_i;
   assign pick_raw[`PICK_CODE_NEG]  = code_neg_i;

   // Each pickup line must stay asserted for the filter time before it
   // counts; reluctance pickups ring, and a glitch would move a magnet
   genvar p;
   generate
      for (p = 0; p < `PICK_COUNT; p = p + 1) begin : g_pick
         reg              meta_reg;
         reg              sync_reg;
         reg [FILT_W-1:0] cnt_reg;

         // Two-stage synchroniser; only the second stage is read
         always @(posedge sys_clk_i) begin
            if (rst_i) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= pick_raw[p];
               sync_reg <= meta_reg;
            end
         end

         // Qualify width; the count parks at its limit so it fires once
         always @(posedge sys_clk_i) begin
            if (rst_i) begin
               cnt_reg <= {FILT_W{1'b0}};
            end else if (!sync_reg) begin
               cnt_reg <= {FILT_W{1'b0}};
            end else if (cnt_reg != PULSE_LAST) begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end

         assign pick_pulse[p] = sync_reg && (cnt_reg == PULSE_LAST - 1'b1);
      end
   endgenerate

   // Only the negative code timing pulse reaches the control
   wire timing_pulse = pick_pulse[`PICK_CODE_NEG];
   wire ph_pos_pulse = pick_pulse[`PICK_PHASE_POS];
   wire ph_neg_pulse = pick_pulse[`PICK_PHASE_NEG];

   // ****************************************************************
   // Code bit and mode synchronisers
   // ****************************************************************
   reg [CHANNELS-1:0] code_meta_reg;
   reg [CHANNELS-1:0] code_sync_reg;
   reg                mode_meta_reg;
   reg                mode_sync_reg;

   // Level inputs from outside the clock domain
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         code_meta_reg <= {CHANNELS{1'b0}};
         code_sync_reg <= {CHANNELS{1'b0}};
         mode_meta_reg <= 1'b0;
         mode_sync_reg <= 1'b0;
      end else begin
         code_meta_reg <= code_bit_i;
         code_sync_reg <= code_meta_reg;
         mode_meta_reg <= single_mag_i;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   // ****************************************************************
   // Phase tracking
   // ****************************************************************
   reg  next_phase_reg;
   reg  next_phase_next;
   reg  fresh_reg;
   reg  fresh_next;
   reg  phase_now;

   // A pulse comes half a revolution ahead of the stationary phase it
   // announces: a positive pulse means the left hole is travelling down,
   // so the coming dwell is phase one; negative means phase zero
   always @* begin
      next_phase_next = next_phase_reg;
      if (ph_pos_pulse && !ph_neg_pulse) begin
         next_phase_next = `PHASE_ONE;
      end else if (ph_neg_pulse && !ph_pos_pulse) begin
         next_phase_next = `PHASE_ZERO;
      end
   end

   // Fresh flag: a phase pulse arriving with the timing pulse wins
   always @* begin
      fresh_next = fresh_reg;
      if (timing_pulse) begin
         fresh_next = 1'b0;
      end
      if (ph_pos_pulse ^ ph_neg_pulse) begin
         fresh_next = 1'b1;
      end
   end

   // Phase for the interval that starts now; without a new pickup pulse
   // the phases simply alternate every positioner cycle
   always @* begin
      if (ph_pos_pulse ^ ph_neg_pulse) begin
         phase_now = next_phase_next;
      end else if (fresh_reg) begin
         phase_now = next_phase_reg;
      end else begin
         phase_now = ~phase_o;
      end
   end

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         next_phase_reg <= `RST_PHASE;
         fresh_reg      <= 1'b0;
      end else begin
         next_phase_reg <= next_phase_next;
         fresh_reg      <= fresh_next;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   localparam [1:0] S_IDLE = 2'h0;   // No phase reference yet
   localparam [1:0] S_SYNC = 2'h1;   // Phase known, waiting for timing
   localparam [1:0] S_RUN  = 2'h2;   // Driving magnets each interval

   reg  [1:0] state_reg;
   reg  [1:0] state_next;
   wire       load_now;

   // Drive starts only once the phase is known, so the first interval
   // cannot couple a pin into the wrong disc
   always @* begin
      case (state_reg)
         S_IDLE: begin
            state_next = (ph_pos_pulse ^ ph_neg_pulse) ? S_SYNC : S_IDLE;
         end
         S_SYNC: begin
            state_next = timing_pulse ? S_RUN : S_SYNC;
         end
         S_RUN: begin
            state_next = S_RUN;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   assign load_now = timing_pulse && (state_next == S_RUN);

   // Interval bookkeeping; phase, code and running flag captured at the negative timing pulse
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         phase_o   <= `RST_PHASE;
         pos_sel_o <= `RST_POS;
         running_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (load_now) begin
            phase_o   <= phase_now;
            pos_sel_o <= code_sync_reg;
            running_o <= 1'b1;
         end
      end
   end

   // Mode is taken with the code so a change cannot split an interval
   reg single_reg;

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         single_reg <= 1'b0;
      end else if (load_now) begin
         single_reg <= mode_sync_reg;
      end
   end

   // ****************************************************************
   // Magnet channels
   // ****************************************************************
   // Selection is made at the timing pulse, ahead of the dwell, so the
   // pin is already pushed when the hole stops
   genvar c;
   generate
      for (c = 0; c < CHANNELS; c = c + 1) begin : g_chan
         magnet_channel u_chan (
            .sys_clk_i (sys_clk_i),
            .rst_i     (rst_i),
            .load_i    (load_now),
            .enable_i  (state_reg != S_IDLE),
            .phase_i   (phase_now),
            .code_i    (code_sync_reg[c]),
            .single_i  (load_now ? mode_sync_reg : single_reg),
            .left_o    (mag_left_o[c]),
            .right_o   (mag_right_o[c])
         );
      end
   endgenerate

endmodule // positioner_magnet_drive

// ---- test/positioner_magnet_drive_asserts.sv ----
// Purpose: Port checks for the positioner magnet drive control
// Assumes: Timing pulses stay high at least 100 clocks
// Notes: Loads land about 101 clocks after the timing pin rises
module positioner_magnet_drive_asserts #(
   parameter integer CHANNELS = 3
) (
   input wire                sys_clk_i,   // Clock
   input wire                rst_i,       // Reset
   input wire                code_neg_i,  // Timing pin
   input wire [CHANNELS-1:0] mag_left_o,  // Left drives
   input wire [CHANNELS-1:0] mag_right_o, // Right drives
   input wire                phase_o,     // Interval phase
   input wire [CHANNELS-1:0] pos_sel_o,   // Latched code
   input wire                running_o    // Drive active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   wire [CHANNELS-1:0] ph = {CHANNELS{phase_o}};
   // Pin quiet long enough that no load can be pending
   sequence pin_quiet;
      !code_neg_i [*5];
   endsequence
   // Pin has been high for most of a valid pulse
   sequence pin_held;
      $past(code_neg_i, 5) && $past(code_neg_i, 95);
   endsequence
   a_xor_select: assert property (|mag_left_o |->
      mag_right_o == (ph ^ pos_sel_o) && mag_left_o == ~mag_right_o)
      else $error("magnet pair not phase xor code");
   a_spring_or: assert property (running_o && mag_left_o == '0 |->
      mag_right_o == (ph | pos_sel_o)) else $error("spring variant drive wrong");
   a_transfer_at_pulse: assert property ($changed({mag_left_o, mag_right_o}) |->
      pin_held) else $error("magnet drive moved away from timing pulse");
   a_phase_at_pulse: assert property ($changed({phase_o, pos_sel_o}) |->
      pin_held) else $error("phase or code moved away from timing pulse");
   a_hold_interval: assert property (pin_quiet |=>
      $stable({mag_left_o, mag_right_o, phase_o, pos_sel_o, running_o}))
      else $error("outputs moved inside an interval");
   a_idle_quiet: assert property (!running_o |->
      {mag_left_o, mag_right_o, phase_o, pos_sel_o} == '0) else $error("drive while idle");
   a_run_sticky: assert property (running_o |=> running_o)
      else $error("drive dropped");
   a_magnet_exclusive: assert property ((mag_left_o & mag_right_o) == '0)
      else $error("both magnets of a channel on");
endmodule // positioner_magnet_drive_asserts

bind positioner_magnet_drive positioner_magnet_drive_asserts #(.CHANNELS(CHANNELS)) u_chk (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .code_neg_i(code_neg_i),
   .mag_left_o(mag_left_o), .mag_right_o(mag_right_o), .phase_o(phase_o),
   .pos_sel_o(pos_sel_o), .running_o(running_o));

// ---- test/pickup_model.sv ----
// Purpose: Phase and code timing pickups of the positioner
// Assumes: Pickup lines are active high and rest low between pulses
// Notes: Pulse length per call, so too-short pulses can be made
module pickup_model (
   input  wire  sys_clk_i,    // Clock
   output logic phase_pos_o,  // Phase pickup, positive
   output logic phase_neg_o,  // Phase pickup, negative
   output logic code_neg_o    // Code timing, negative only
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {phase_pos_o, phase_neg_o, code_neg_o} = 3'h0;
   // One pulse then a quiet gap so lines never overlap
   task automatic pulse(input logic [2:0] lines, input int len);
      @(posedge sys_clk_i);
      #1 {phase_pos_o, phase_neg_o, code_neg_o} = lines;
      repeat (len) @(posedge sys_clk_i);
      #1 {phase_pos_o, phase_neg_o, code_neg_o} = 3'h0;
      repeat (20) @(posedge sys_clk_i);
   endtask
   // Polarity names the coming phase
   task automatic phase(input logic one);
      pulse(one ? 3'h4 : 3'h2, 110);
   endtask
   // Positive timing pulse goes to companion gear, never made here
   task automatic timing(input int len);
      pulse(3'h1, len);
   endtask
endmodule // pickup_model

// ---- test/test_positioner_magnet_drive.sv ----
// Purpose: Self-checking bench for the positioner magnet drive
// Assumes: Filter needs 99 clocks, pulses here last 110
// Notes: Expected drive is worked out from phase and code here
module test_positioner_magnet_drive;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [2:0] code_bit_i = 3'h0;
   logic       single_mag_i = 1'b0;
   logic       exp_ph = 1'b0;
   wire        phase_pos_i, phase_neg_i, code_neg_i, phase_o, running_o;
   wire  [2:0] mag_left_o, mag_right_o, pos_sel_o;
   int         mismatches = 0;
   int         total_checks = 0;
   int         cycles = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   pickup_model pick (.sys_clk_i(sys_clk_i), .phase_pos_o(phase_pos_i),
      .phase_neg_o(phase_neg_i), .code_neg_o(code_neg_i));
   positioner_magnet_drive dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .phase_pos_i(phase_pos_i), .phase_neg_i(phase_neg_i), .code_neg_i(code_neg_i),
      .code_bit_i(code_bit_i), .single_mag_i(single_mag_i), .mag_left_o(mag_left_o),
      .mag_right_o(mag_right_o), .phase_o(phase_o), .pos_sel_o(pos_sel_o),
      .running_o(running_o));
   task automatic check(input string what, input logic [3:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard, about twice the expected run
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles > 15000) begin
         mismatches++;
         report_and_stop;
      end
   end
   task automatic check_out(input logic [2:0] code);
      logic [2:0] r;
      logic [2:0] l;
      r = single_mag_i ? ({3{exp_ph}} | code) : ({3{exp_ph}} ^ code);
      // Inverse taken at three bits so no widened ones leak in
      l = single_mag_i ? 3'h0 : ~r;
      check("right", mag_right_o, r);
      check("left", mag_left_o, l);
      check("pos_sel", pos_sel_o, code);
      check("phase", phase_o, exp_ph);
      check("running", running_o, 1'b1);
   endtask
   // Code, then phase pulse (pol 0/1, or none when -1), then timing pulse
   task automatic interval(input logic [2:0] code, input int pol);
      @(posedge sys_clk_i);
      #1 code_bit_i = code;
      if (pol >= 0) pick.phase(pol[0]);
      exp_ph = (pol >= 0) ? pol[0] : ~exp_ph;
      pick.timing(110);
      check_out(code);
   endtask
   // Timing pulse before any phase pulse must give no drive
   task automatic test_idle;
      check("idle", {running_o, mag_right_o}, 4'h0);
      code_bit_i = 3'h7;
      pick.timing(110);
      check("refused", {running_o, mag_right_o | mag_left_o}, 4'h0);
   endtask
   task automatic test_table;
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 8; c++) interval(c[2:0], p);
   endtask
   // Code moves and a glitch arrives mid-interval: nothing may follow
   task automatic test_hold;
      interval(3'h3, 0);
      @(posedge sys_clk_i);
      #1 code_bit_i = 3'h4;
      pick.timing(40);
      repeat (150) @(posedge sys_clk_i);
      check_out(3'h3);
   endtask
   task automatic test_toggle;
      interval(3'h5, -1);
      interval(3'h2, -1);
   endtask
   task automatic test_single;
      @(posedge sys_clk_i);
      #1 single_mag_i = 1'b1;
      for (int p = 0; p < 2; p++) begin
         interval(3'h2, p);
         interval(3'h0, p);
      end
   endtask
   // Reset in mid-run clears all outputs; drive waits for a new phase pulse
   task automatic test_reset;
      @(posedge sys_clk_i);
      #1 rst_i = 1'b1;
      single_mag_i = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      check("rst_mag", mag_left_o | mag_right_o, 3'h0);
      check("rst_state", {phase_o, running_o}, 2'h0);
      check("rst_pos", pos_sel_o, 3'h0);
      pick.timing(110);
      check("rst_refused", {running_o, mag_right_o | mag_left_o}, 4'h0);
      interval(3'h6, 1);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      test_idle;
      test_table;
      test_hold;
      test_toggle;
      test_single;
      test_reset;
      report_and_stop;
   end
endmodule // test_positioner_magnet_drive
